// file: src/fbc_pkg.sv
/*
  Package for the flash command host controller: command codes, unlock
  addresses, query offsets, software port map and bus timing counts.
  Assumes a 50 MHz clock and a byte-wide flash on an asynchronous bus.
*/
package fbc_pkg;

  // ****************************************************************
  // Flash command codes
  // ****************************************************************
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_IDQUERY = 8'h90;
  localparam logic [7:0] CMD_REGION_IN = 8'h88;
  localparam logic [7:0] CMD_EXIT_DATA = 8'h00;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_COMMIT = 8'h29;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_PARAM_QUERY = 8'h98;

  // ****************************************************************
  // Flash addresses and query offsets
  // ****************************************************************
  localparam int FA_W = 22;
  localparam logic [FA_W-1:0] ADDR_UNLOCK1 = 22'h000AAA;
  localparam logic [FA_W-1:0] ADDR_UNLOCK2 = 22'h000555;
  localparam logic [FA_W-1:0] ADDR_PARAM_QUERY = 22'h0000AA;
  localparam logic [FA_W-1:0] OFS_MAKER = 22'h000000;
  localparam logic [FA_W-1:0] OFS_DEV1 = 22'h000002;
  localparam logic [FA_W-1:0] OFS_DEV2 = 22'h00001C;
  localparam logic [FA_W-1:0] OFS_DEV3 = 22'h00001E;
  localparam logic [FA_W-1:0] OFS_GROUP_PROT = 22'h000004;
  localparam logic [FA_W-1:0] OFS_REGION_LOCK = 22'h000006;
  localparam int SECTOR_LSB = 15;
  localparam logic [FA_W-1:0] SECTOR_MASK = 22'h3F8000;
  localparam int BUF_MAX_BYTES = 32;
  localparam int BUF_MAX_CYCLES = 37;

  // Status bit positions on the data bus
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_ONE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int ERASE_TIMER_BIT = 3;
  localparam int TOGGLE_TWO_BIT = 2;

  // ****************************************************************
  // Software port map
  // ****************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h5;
  localparam logic [3:0] REG_BUFWR = 4'h6;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 5;

  // ****************************************************************
  // Bus timing, in ns, and derived cycle counts at 50 MHz
  // ****************************************************************
  localparam int CLK_NS = 20;
  localparam int T_WE_PULSE_NS = 40;
  localparam int T_WE_HIGH_NS = 40;
  localparam int T_READ_NS = 100;
  localparam int WE_CYC = (T_WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WH_CYC = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int TM_W = 4;

  // Operation codes written to the control register
  typedef enum logic [4:0] {
    FBC_OP_READ, FBC_OP_RESET, FBC_OP_ID_MAKER, FBC_OP_ID_DEVICE,
    FBC_OP_REGION_LOCK, FBC_OP_GROUP_PROT, FBC_OP_REGION_IN,
    FBC_OP_REGION_OUT, FBC_OP_PROGRAM, FBC_OP_BUF_PROGRAM,
    FBC_OP_BUF_ABORT, FBC_OP_BYPASS_IN, FBC_OP_BYPASS_PROG,
    FBC_OP_BYPASS_OUT, FBC_OP_CHIP_ERASE, FBC_OP_SECTOR_ERASE,
    FBC_OP_SUSPEND, FBC_OP_RESUME, FBC_OP_PARAM_QUERY, FBC_OP_STATUS
  } fbc_op_e;

  // Flash pin group driven by the controller
  typedef struct packed {
    logic [FA_W-1:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } fbc_pins_s;

endpackage

// file: src/fbc_host.sv
/*
  Host controller that drives a byte-wide NOR flash through its command
  sequences. Software posts an operation over a simple register port;
  the controller plays the write and read cycles on the flash pins and
  reports read data, toggle status and the ready/busy pin.
  Assumes the flash pins and ready/busy are asynchronous to clk.
*/
// Functional notes
// - Unlock writes AA at AAA, 55 at 555
// - F0 returns device to read mode
// - ID query: 90 at AAA, then read
// - Device ID read at 02, 1C, 1E
// - Program: unlock, A0, data at address
// - Buffer: unlock, 25, count, address/data pairs
// - Buffered sequence at most 37 cycles
// - 29 at sector commits buffer
// - Abort recovery: unlock then F0
// - Bypass entry 20; two-cycle program inside
// - Bypass exit: 90 then 00
// - Erase: six cycles, 10 chip, 30 sector
// - B0 suspends; only during sector erase; the host sends B0 and sets suspended in any state
module fbc_host
  import fbc_pkg::*;
#(
  parameter int BUF_BYTES = BUF_MAX_BYTES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic [FA_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  input wire logic ready_busy_pin
);

  localparam int BI_W = $clog2(BUF_BYTES);
  localparam int SQ_W = 6;

  typedef enum logic [2:0] {
    FBC_ST_IDLE, FBC_ST_SETUP, FBC_ST_PULSE, FBC_ST_HOLD, FBC_ST_RDWAIT
  } fbc_state_e;

  typedef struct packed {
    fbc_state_e st;
    fbc_pins_s pins;
    logic [TM_W-1:0] tmr;
    logic [SQ_W-1:0] step;
    logic [SQ_W-1:0] last;
    fbc_op_e op;
    logic [FA_W-1:0] addr;
    logic [7:0] data;
    logic [BI_W-1:0] count;
    logic [BUF_BYTES-1:0][7:0] buf_d;
    logic [BI_W-1:0] wr_idx;
    logic [7:0] rdata;
    logic [7:0] prev_rd;
    logic toggling;
    logic busy_flag;
    logic suspended;
    logic bypass;
    logic rb_s1;
    logic rb_s2;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic [31:0] sw_rdata;
  } fbc_state_s;

  fbc_state_s q_r, q_nxt;

  // ****************************************************************
  // Sequence table: step -> address/data/read
  // ****************************************************************
  logic [FA_W-1:0] cyc_addr;
  logic [7:0] cyc_data;
  logic cyc_read;
  logic [SQ_W-1:0] bi;
  logic [FA_W-1:0] sect;

  always_comb begin
    cyc_addr = ADDR_UNLOCK1;
    cyc_data = CMD_UNLOCK1;
    cyc_read = 1'b0;
    sect = q_r.addr & SECTOR_MASK;
    bi = q_r.step - SQ_W'(4);
    if (q_r.step == SQ_W'(1)) begin
      cyc_addr = ADDR_UNLOCK2;
      cyc_data = CMD_UNLOCK2;
    end
    case (q_r.op)
      FBC_OP_READ, FBC_OP_STATUS: begin
        cyc_addr = q_r.addr;
        cyc_read = 1'b1;
      end
      FBC_OP_RESET: begin
        cyc_addr = q_r.addr;
        cyc_data = CMD_RESET;
      end
      FBC_OP_ID_MAKER, FBC_OP_ID_DEVICE, FBC_OP_REGION_LOCK,
      FBC_OP_GROUP_PROT, FBC_OP_REGION_OUT: begin
        if (q_r.step == SQ_W'(2)) begin
          cyc_data = CMD_IDQUERY;
        end else if (q_r.step >= SQ_W'(3)) begin
          cyc_read = (q_r.op != FBC_OP_REGION_OUT);
          cyc_data = CMD_EXIT_DATA;
          case (q_r.op)
            FBC_OP_ID_MAKER: cyc_addr = OFS_MAKER;
            FBC_OP_ID_DEVICE: begin
              cyc_addr = (q_r.step == SQ_W'(3)) ? OFS_DEV1 :
                (q_r.step == SQ_W'(4)) ? OFS_DEV2 : OFS_DEV3;
            end
            FBC_OP_REGION_LOCK: cyc_addr = OFS_REGION_LOCK;
            FBC_OP_GROUP_PROT: cyc_addr = sect | OFS_GROUP_PROT;
            default: cyc_addr = q_r.addr;
          endcase
        end
      end
      FBC_OP_REGION_IN: begin
        if (q_r.step == SQ_W'(2)) cyc_data = CMD_REGION_IN;
      end
      FBC_OP_PROGRAM: begin
        if (q_r.step == SQ_W'(2)) cyc_data = CMD_PROGRAM;
        if (q_r.step == SQ_W'(3)) begin
          cyc_addr = q_r.addr;
          cyc_data = q_r.data;
        end
      end
      FBC_OP_BUF_PROGRAM: begin
        if (q_r.step == SQ_W'(2)) begin
          cyc_addr = sect;
          cyc_data = CMD_BUF_LOAD;
        end else if (q_r.step == SQ_W'(3)) begin
          cyc_addr = sect;
          cyc_data = 8'(q_r.count);
        end else if (q_r.step == q_r.last) begin
          cyc_addr = sect;
          cyc_data = CMD_BUF_COMMIT;
        end else if (q_r.step >= SQ_W'(4)) begin
          cyc_addr = q_r.addr + FA_W'(bi); // same page as first
          cyc_data = q_r.buf_d[bi[BI_W-1:0]];
        end
      end
      FBC_OP_BUF_ABORT: begin
        if (q_r.step == SQ_W'(2)) cyc_data = CMD_RESET;
      end
      FBC_OP_BYPASS_IN: begin
        if (q_r.step == SQ_W'(2)) cyc_data = CMD_BYPASS;
      end
      FBC_OP_BYPASS_PROG: begin
        cyc_addr = q_r.addr;
        cyc_data = (q_r.step == SQ_W'(0)) ? CMD_PROGRAM : q_r.data;
      end
      FBC_OP_BYPASS_OUT: begin
        cyc_addr = q_r.addr;
        cyc_data = (q_r.step == SQ_W'(0)) ? CMD_IDQUERY : CMD_EXIT_DATA;
      end
      FBC_OP_CHIP_ERASE, FBC_OP_SECTOR_ERASE: begin
        case (q_r.step)
          SQ_W'(2): cyc_data = CMD_ERASE_SETUP;
          SQ_W'(4): begin
            cyc_addr = ADDR_UNLOCK2;
            cyc_data = CMD_UNLOCK2;
          end
          SQ_W'(5): begin
            if (q_r.op == FBC_OP_SECTOR_ERASE) begin
              cyc_addr = sect;
              cyc_data = CMD_SECTOR_ERASE;
            end else begin
              cyc_data = CMD_CHIP_ERASE;
            end
          end
          default: ;
        endcase
      end
      FBC_OP_SUSPEND: begin
        cyc_addr = q_r.addr;
        cyc_data = CMD_SUSPEND;
      end
      FBC_OP_RESUME: begin
        cyc_addr = q_r.addr;
        cyc_data = CMD_RESUME;
      end
      FBC_OP_PARAM_QUERY: begin
        cyc_addr = ADDR_PARAM_QUERY;
        cyc_data = CMD_PARAM_QUERY;
      end
      default: ;
    endcase
  end

  // Number of cycles in each sequence, minus one
  function automatic logic [SQ_W-1:0] seq_last(input fbc_op_e op,
      input logic [BI_W-1:0] cnt);
    case (op)
      FBC_OP_ID_MAKER, FBC_OP_REGION_LOCK, FBC_OP_GROUP_PROT,
      FBC_OP_PROGRAM, FBC_OP_REGION_OUT: seq_last = SQ_W'(3);
      FBC_OP_ID_DEVICE: seq_last = SQ_W'(5);
      FBC_OP_REGION_IN, FBC_OP_BUF_ABORT, FBC_OP_BYPASS_IN:
        seq_last = SQ_W'(2);
      FBC_OP_BYPASS_PROG, FBC_OP_BYPASS_OUT: seq_last = SQ_W'(1);
      FBC_OP_CHIP_ERASE, FBC_OP_SECTOR_ERASE: seq_last = SQ_W'(5);
      // 4 header writes, count+1 pairs, one commit; 37 cycles at most
      FBC_OP_BUF_PROGRAM: seq_last = SQ_W'(cnt) + SQ_W'(5);
      default: seq_last = SQ_W'(0);
    endcase
  endfunction

  // ****************************************************************
  // Main state update
  // ****************************************************************
  logic [7:0] rd_now;
  fbc_op_e new_op;

  always_comb begin
    q_nxt = q_r;
    rd_now = q_r.dq_s2;
    new_op = fbc_op_e'(sw_wdata[CTRL_OP_LSB +: CTRL_OP_W]);
    // Pins pass two flops before use
    q_nxt.rb_s1 = ready_busy_pin;
    q_nxt.rb_s2 = q_r.rb_s1;
    q_nxt.dq_s1 = flash_dq_in;
    q_nxt.dq_s2 = q_r.dq_s1;
    q_nxt.busy_flag = ~q_r.rb_s2;
    q_nxt.sw_rdata = 32'h0;
    if (sw_rd) begin
      case (sw_addr)
        REG_CTRL: q_nxt.sw_rdata = 32'(q_r.op);
        REG_ADDR: q_nxt.sw_rdata = 32'(q_r.addr);
        REG_DATA: q_nxt.sw_rdata = 32'(q_r.data);
        REG_STATUS: q_nxt.sw_rdata = {26'h0, q_r.bypass, q_r.suspended,
          q_r.toggling, q_r.busy_flag, 1'b0, (q_r.st != FBC_ST_IDLE)};
        REG_RDATA: q_nxt.sw_rdata = 32'(q_r.rdata);
        REG_COUNT: q_nxt.sw_rdata = 32'(q_r.count);
        default: q_nxt.sw_rdata = 32'h0;
      endcase
    end
    // Writes while a sequence runs are dropped so no cycle is torn
    if (sw_wr && q_r.st == FBC_ST_IDLE) begin
      case (sw_addr)
        REG_ADDR: q_nxt.addr = sw_wdata[FA_W-1:0];
        REG_DATA: q_nxt.data = sw_wdata[7:0];
        REG_COUNT: begin
          q_nxt.count = sw_wdata[BI_W-1:0]; // locations minus one
          q_nxt.wr_idx = '0;
        end
        REG_BUFWR: begin
          q_nxt.buf_d[q_r.wr_idx] = sw_wdata[7:0];
          q_nxt.wr_idx = q_r.wr_idx + BI_W'(1);
        end
        REG_CTRL: begin
          q_nxt.op = new_op;
          q_nxt.step = '0;
          q_nxt.last = seq_last(new_op, q_r.count);
          q_nxt.st = FBC_ST_SETUP;
        end
        default: ;
      endcase
    end
    case (q_r.st)
      FBC_ST_IDLE: ;
      FBC_ST_SETUP: begin
        q_nxt.pins.addr = cyc_addr;
        q_nxt.pins.dq_out = cyc_data;
        q_nxt.pins.dq_oe = ~cyc_read;
        q_nxt.pins.ce_n = 1'b0;
        q_nxt.pins.we_n = cyc_read; // address set on the same edge as strobe falls
        q_nxt.pins.oe_n = ~cyc_read;
        q_nxt.tmr = cyc_read ? TM_W'(RD_CYC) : TM_W'(WE_CYC);
        q_nxt.st = cyc_read ? FBC_ST_RDWAIT : FBC_ST_PULSE;
      end
      FBC_ST_PULSE: begin
        if (q_r.tmr == TM_W'(1)) begin
          q_nxt.pins.we_n = 1'b1; // data held across rising edge
          q_nxt.pins.ce_n = 1'b1;
          q_nxt.tmr = TM_W'(WH_CYC);
          q_nxt.st = FBC_ST_HOLD;
        end else begin
          q_nxt.tmr = q_r.tmr - TM_W'(1);
        end
      end
      FBC_ST_RDWAIT: begin
        if (q_r.tmr == TM_W'(1)) begin
          q_nxt.pins.oe_n = 1'b1;
          q_nxt.pins.ce_n = 1'b1;
          q_nxt.rdata = rd_now;
          q_nxt.prev_rd = rd_now;
          // Toggle one flips between reads while an operation runs
          q_nxt.toggling = rd_now[TOGGLE_ONE_BIT] ^
            q_r.prev_rd[TOGGLE_ONE_BIT];
          q_nxt.tmr = TM_W'(WH_CYC);
          q_nxt.st = FBC_ST_HOLD;
        end else begin
          q_nxt.tmr = q_r.tmr - TM_W'(1);
        end
      end
      FBC_ST_HOLD: begin
        q_nxt.pins.dq_oe = 1'b0;
        if (q_r.tmr > TM_W'(1)) begin
          q_nxt.tmr = q_r.tmr - TM_W'(1);
        end else if (q_r.step == q_r.last) begin
          q_nxt.st = FBC_ST_IDLE;
          case (q_r.op)
            FBC_OP_BYPASS_IN: q_nxt.bypass = 1'b1;
            FBC_OP_BYPASS_OUT, FBC_OP_RESET: q_nxt.bypass = 1'b0;
            FBC_OP_SUSPEND: q_nxt.suspended = 1'b1;
            FBC_OP_RESUME: q_nxt.suspended = 1'b0;
            default: ;
          endcase
        end else begin
          q_nxt.step = q_r.step + SQ_W'(1);
          q_nxt.st = FBC_ST_SETUP;
        end
      end
      default: q_nxt.st = FBC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '0;
      q_r.st <= FBC_ST_IDLE;
      q_r.pins.ce_n <= 1'b1;
      q_r.pins.we_n <= 1'b1;
      q_r.pins.oe_n <= 1'b1;
      q_r.rb_s1 <= 1'b1;
      q_r.rb_s2 <= 1'b1;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  assign sw_rdata = q_r.sw_rdata;
  assign flash_addr = q_r.pins.addr;
  assign flash_dq_out = q_r.pins.dq_out;
  assign flash_dq_oe = q_r.pins.dq_oe;
  assign flash_ce_n = q_r.pins.ce_n;
  assign flash_we_n = q_r.pins.we_n;
  assign flash_oe_n = q_r.pins.oe_n;

endmodule

// file: bench/fbc_host_monitor.sv
/*
  Checker of the flash pin cycles that fbc_host drives.
  Assumes one clock and a synchronous active-high reset.
*/
module fbc_host_monitor
  import fbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [FA_W-1:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  // ********
  // Write cycles
  // ********
  property p_we_pulse;
    $fell(flash_we_n) |-> !flash_ce_n ##1 !flash_we_n ##1 flash_we_n && flash_ce_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write strobe shape wrong");
  property p_addr_held;
    !flash_we_n |=> $stable(flash_addr) && $stable(flash_dq_out);
  endproperty
  a_addr_held: assert property (p_addr_held)
    else $error("address or data moved under write strobe");
  property p_data_hold;
    $rose(flash_we_n) |-> flash_dq_oe;
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data released before strobe rose");
  property p_write_gap;
    $rose(flash_we_n) |-> flash_we_n [*2];
  endproperty
  a_write_gap: assert property (p_write_gap)
    else $error("write strobes too close");
  property p_unlock2;
    $fell(flash_we_n) && flash_addr[11:0] == 12'h555 |-> flash_dq_out == CMD_UNLOCK2;
  endproperty
  a_unlock2: assert property (p_unlock2)
    else $error("second unlock data wrong");
  // ********
  // Read cycles
  // ********
  property p_no_fight;
    !flash_oe_n |-> flash_we_n && !flash_dq_oe;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("host drives data during a read");
  property p_read_len;
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n) [*5] ##1 flash_oe_n;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read strobe length wrong");
  property p_ce_idle;
    flash_ce_n |-> flash_we_n && flash_oe_n;
  endproperty
  a_ce_idle: assert property (p_ce_idle)
    else $error("strobe without chip enable");
endmodule

// file: bench/fbc_flash_model.sv
/*
  Behavioural byte-wide flash: command decode, identity reads, status.
  Assumes fbc_host pins; every write is logged for the bench.
*/
module fbc_flash_model
  import fbc_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV = 8'h3C, // Arbitrary value
  parameter int PROG_NS = 4000,
  parameter int ERASE_NS = 5000
) (
  input wire logic [FA_W-1:0] addr,
  input wire logic [7:0] dq_out,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic [7:0] dq_in,
  output logic ready_busy_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [29:0] wlog[$];
  logic [7:0] mem[logic [FA_W-1:0]];
  logic [29:0] h1 = '0, h2 = '0, w;
  logic [FA_W-1:0] la;
  logic [7:0] rd = 8'h00;
  logic id_m = 0, byp = 0, prog = 0, er = 0, era = 0, sus = 0, pol = 0, tog = 0;
  logic sec = 0, cfi = 0;
  int left = 0;
  always #20 if (left > 0 && !sus) left -= 20;
  assign ready_busy_pin = !(left > 0 && !sus);
  // ********
  // Write decode
  // ********
  always @(negedge we_n) #1 la = addr;
  always @(posedge we_n) begin
    w = {la, dq_out};
    wlog.push_back(w);
    if (prog) begin
      prog = 0;
      mem[la] = dq_out;
      pol = ~dq_out[7];
      left = PROG_NS;
    end else if (w[7:0] == CMD_RESET) begin
      id_m = 0;
      cfi = 0;
    end else if (w[7:0] == CMD_SUSPEND) begin
      sus = era && left > 0;
    end else if (sus && w[7:0] == CMD_RESUME) begin
      sus = 0;
    end else if (w[19:0] == {ADDR_PARAM_QUERY[11:0], CMD_PARAM_QUERY} && left == 0) begin
      cfi = 1;
    end else if (byp) begin
      prog = w[7:0] == CMD_PROGRAM;
      byp = !(h1[7:0] == CMD_IDQUERY && w[7:0] == CMD_EXIT_DATA);
    end else if (h2[19:0] == {ADDR_UNLOCK1[11:0], CMD_UNLOCK1}
      && h1[19:0] == {ADDR_UNLOCK2[11:0], CMD_UNLOCK2}) begin
      case (w[7:0])
        CMD_IDQUERY: id_m = 1;
        CMD_PROGRAM: prog = 1;
        CMD_BYPASS: byp = 1;
        CMD_REGION_IN: sec = 1;
        CMD_ERASE_SETUP: er = 1;
        CMD_CHIP_ERASE, CMD_SECTOR_ERASE: if (er) begin
          er = 0;
          era = w[7:0] == CMD_SECTOR_ERASE;
          pol = 0;
          mem.delete();
          left = ERASE_NS;
        end
        default: er = 0;
      endcase
    end else if (id_m && w[7:0] == CMD_EXIT_DATA) begin
      id_m = 0;
      sec = 0;
    end
    h2 = h1;
    h1 = w;
  end
  // ********
  // Read answer
  // ********
  always @(negedge oe_n) begin
    #1;
    if (left > 0 && !sus) begin
      tog = ~tog;
      rd = {pol, tog, 6'h00};
    end else if (id_m) begin
      case (addr[7:0])
        OFS_MAKER[7:0]: rd = MAKER;
        OFS_DEV1[7:0], OFS_DEV2[7:0], OFS_DEV3[7:0]: rd = DEV ^ addr[7:0];
        OFS_REGION_LOCK[7:0]: rd = 8'h98;
        OFS_GROUP_PROT[7:0]: rd = 8'h01;
        default: rd = 8'hFF;
      endcase
    end else begin
      rd = mem.exists(addr) ? mem[addr] : 8'hFF;
    end
  end
  // Released bus shows the inverse so stale data never passes as good
  assign dq_in = (!ce_n && !oe_n) ? rd : ~rd;
endmodule

// file: bench/fbc_host_tb_top.sv
/*
  Bench top: fbc_host against the flash model, one task per scenario.
  Assumes package, host, model and monitor are compiled first.
*/
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module fbc_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fbc_pkg::*;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary value
  localparam logic [7:0] DV = 8'h3C; // Arbitrary value
  logic clk = 0;
  logic reset = 1;
  logic sw_wr = 0;
  logic sw_rd = 0;
  logic [3:0] sw_addr = '0;
  logic [31:0] sw_wdata = '0;
  logic [31:0] sw_rdata, rv;
  logic [FA_W-1:0] fa;
  logic [7:0] fdo, fdi;
  logic foe, ce_n, we_n, oe_n, rb;
  int n_errors = 0;
  int checked = 0;
  always #10 clk = ~clk;
  fbc_host u_dut (.clk(clk), .reset(reset), .clk_en(1'b1), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .flash_addr(fa), .flash_dq_out(fdo), .flash_dq_oe(foe), .flash_dq_in(fdi),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .ready_busy_pin(rb));
  fbc_flash_model #(.MAKER(MK), .DEV(DV)) u_flash (.addr(fa), .dq_out(fdo),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_in(fdi), .ready_busy_pin(rb));
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ********
  // Bus cycles and checks
  // ********
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    // Gap edge keeps the strobe from being assigned twice in one step
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 rv = sw_rdata;
    @(posedge clk);
  endtask
  task automatic poll(input int b);
    for (int i = 0; i < 400; i++) begin
      rd(REG_STATUS);
      if (rv[b] === 1'b0) return;
    end
    `CHK("status wait", 1'b0, 1'b1)
    give_verdict();
  endtask
  task automatic op(input fbc_op_e o, input logic [FA_W-1:0] a, input logic [7:0] d);
    wr(REG_ADDR, 32'(a));
    wr(REG_DATA, 32'(d));
    u_flash.wlog.delete();
    wr(REG_CTRL, 32'(o));
    @(posedge clk);
    poll(0);
  endtask
  task automatic ew(input int i, input logic [FA_W-1:0] a, input logic [7:0] d);
    `CHK("flash write", {a, d}, u_flash.wlog[i])
  endtask
  task automatic eu;
    ew(0, ADDR_UNLOCK1, CMD_UNLOCK1);
    ew(1, ADDR_UNLOCK2, CMD_UNLOCK2);
  endtask
  task automatic st(input int b, input logic v);
    rd(REG_STATUS);
    `CHK("status bit", v, rv[b])
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_basic;
    rd(4'hF);
    `CHK("unmapped", 32'h0, rv)
    op(FBC_OP_RESET, 22'h3FF0AA, 8'h00);
    ew(0, 22'h3FF0AA, CMD_RESET);
    op(FBC_OP_PARAM_QUERY, 22'h0, 8'h00);
    ew(0, ADDR_PARAM_QUERY, CMD_PARAM_QUERY);
    `CHK("param query", 1'b1, u_flash.cfi)
  endtask
  task automatic t_ids;
    fbc_op_e ops[4] = '{FBC_OP_ID_MAKER, FBC_OP_ID_DEVICE, FBC_OP_REGION_LOCK,
      FBC_OP_GROUP_PROT};
    logic [7:0] ex[4] = '{MK, DV ^ 8'h1E, 8'h98, 8'h01};
    for (int i = 0; i < 4; i++) begin
      op(ops[i], 22'h018000, 8'h00);
      eu();
      ew(2, ADDR_UNLOCK1, CMD_IDQUERY);
      rd(REG_RDATA);
      `CHK("id byte", 32'(ex[i]), rv)
    end
    op(FBC_OP_RESET, 22'h0, 8'h00);
  endtask
  task automatic t_region;
    op(FBC_OP_REGION_IN, 22'h0, 8'h00);
    eu();
    ew(2, ADDR_UNLOCK1, CMD_REGION_IN);
    `CHK("region in", 1'b1, u_flash.sec)
    op(FBC_OP_REGION_OUT, 22'h0, 8'h00);
    ew(2, ADDR_UNLOCK1, CMD_IDQUERY);
    `CHK("exit data", CMD_EXIT_DATA, u_flash.wlog[3][7:0])
    `CHK("region out", 1'b0, u_flash.sec)
    op(FBC_OP_BUF_ABORT, 22'h0, 8'h00);
    eu();
    ew(2, ADDR_UNLOCK1, CMD_RESET);
  endtask
  task automatic t_prog;
    op(FBC_OP_PROGRAM, 22'h012345, 8'h5C);
    eu();
    ew(2, ADDR_UNLOCK1, CMD_PROGRAM);
    ew(3, 22'h012345, 8'h5C);
    st(2, 1'b1);
    op(FBC_OP_STATUS, 22'h012345, 8'h00);
    op(FBC_OP_STATUS, 22'h012345, 8'h00);
    rd(REG_RDATA);
    `CHK("poll bit", 1'b1, rv[7])
    st(3, 1'b1);
    poll(2);
    op(FBC_OP_STATUS, 22'h012345, 8'h00);
    op(FBC_OP_STATUS, 22'h012345, 8'h00);
    st(3, 1'b0);
    op(FBC_OP_READ, 22'h012345, 8'h00);
    rd(REG_RDATA);
    `CHK("array byte", 32'h5C, rv)
  endtask
  task automatic t_bypass;
    op(FBC_OP_BYPASS_IN, 22'h0, 8'h00);
    eu();
    ew(2, ADDR_UNLOCK1, CMD_BYPASS);
    st(5, 1'b1);
    op(FBC_OP_BYPASS_PROG, 22'h022222, 8'h3C);
    `CHK("bypass cmd", CMD_PROGRAM, u_flash.wlog[0][7:0])
    ew(1, 22'h022222, 8'h3C);
    poll(2);
    op(FBC_OP_BYPASS_OUT, 22'h0, 8'h00);
    `CHK("bypass exit", {CMD_IDQUERY, CMD_EXIT_DATA}, {u_flash.wlog[0][7:0], u_flash.wlog[1][7:0]})
    st(5, 1'b0);
    op(FBC_OP_READ, 22'h022222, 8'h00);
    rd(REG_RDATA);
    `CHK("bypass byte", 32'h3C, rv)
  endtask
  task automatic t_buf;
    wr(REG_COUNT, 32'h1);
    wr(REG_BUFWR, 32'hA1);
    wr(REG_BUFWR, 32'hB2);
    op(FBC_OP_BUF_PROGRAM, 22'h018010, 8'h00);
    eu();
    ew(2, 22'h018000, CMD_BUF_LOAD);
    ew(3, 22'h018000, 8'h01);
    ew(4, 22'h018010, 8'hA1);
    ew(5, 22'h018011, 8'hB2);
    ew(6, 22'h018000, CMD_BUF_COMMIT);
    `CHK("buffer cycles", 7, u_flash.wlog.size())
  endtask
  task automatic t_erase;
    op(FBC_OP_SECTOR_ERASE, 22'h018000, 8'h00);
    eu();
    ew(2, ADDR_UNLOCK1, CMD_ERASE_SETUP);
    ew(3, ADDR_UNLOCK1, CMD_UNLOCK1);
    ew(4, ADDR_UNLOCK2, CMD_UNLOCK2);
    ew(5, 22'h018000, CMD_SECTOR_ERASE);
    op(FBC_OP_SUSPEND, 22'h018000, 8'h00);
    ew(0, 22'h018000, CMD_SUSPEND);
    poll(2);
    st(4, 1'b1);
    op(FBC_OP_RESUME, 22'h018000, 8'h00);
    ew(0, 22'h018000, CMD_RESUME);
    st(4, 1'b0);
    poll(2);
    op(FBC_OP_CHIP_ERASE, 22'h0, 8'h00);
    ew(5, ADDR_UNLOCK1, CMD_CHIP_ERASE);
    poll(2);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_basic();
    t_ids();
    t_region();
    t_prog();
    t_bypass();
    t_buf();
    t_erase();
    give_verdict();
  end
endmodule
bind fbc_host fbc_host_monitor u_mon (.clk(clk), .reset(reset), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
